// ### audio_link_pkg.sv
package audio_link_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // register byte addresses
   localparam logic [31:0] ADDR_CONFIG        = 32'h1002_0000;
   localparam logic [31:0] ADDR_COMMON_CTRL   = 32'h1002_0004;
   localparam logic [31:0] ADDR_ACLINK_CTRL1  = 32'h1002_0008;
   localparam logic [31:0] ADDR_ACLINK_CTRL2  = 32'h1002_000C;
   localparam logic [31:0] ADDR_SERIAL_CTRL   = 32'h1002_0010;
   localparam logic [31:0] ADDR_FIFO_STATUS   = 32'h1002_0014;
   localparam logic [31:0] ADDR_ACLINK_STAT   = 32'h1002_0018;
   localparam logic [31:0] ADDR_SERIAL_STAT   = 32'h1002_001C;
   localparam logic [31:0] ADDR_CMD_ADDRESS   = 32'h1002_0020;
   localparam logic [31:0] ADDR_CMD_DATA      = 32'h1002_0024;
   localparam logic [31:0] ADDR_STAT_ADDRESS  = 32'h1002_0028;
   localparam logic [31:0] ADDR_STAT_DATA     = 32'h1002_002C;
   localparam logic [31:0] ADDR_BCLK_DIVIDER  = 32'h1002_0030;
   localparam logic [31:0] ADDR_FIFO_DATA     = 32'h1002_0034;
   localparam logic [31:0] ADDR_EMB_CLK_CFG   = 32'h1002_00A0;
   localparam logic [31:0] ADDR_EMB_REG_WRITE = 32'h1002_00A4;
   localparam logic [31:0] ADDR_EMB_REG_READ  = 32'h1002_00A8;

   // plain read/write storage registers, one entry each
   localparam int          GP_N = 10;
   localparam logic [31:0] GP_ADDR [GP_N] = '{ADDR_COMMON_CTRL, ADDR_ACLINK_CTRL1, ADDR_ACLINK_CTRL2,
                                              ADDR_SERIAL_CTRL, ADDR_ACLINK_STAT, ADDR_SERIAL_STAT,
                                              ADDR_CMD_ADDRESS, ADDR_CMD_DATA, ADDR_EMB_CLK_CFG,
                                              ADDR_EMB_REG_WRITE};
   localparam int          GP_CMD_ADDR = 6;
   localparam int          GP_CMD_DATA = 7;

   ////////////////////////////////////////////////////////////////////////////////
   // configuration register fields
   localparam int CFG_RX_TH_LSB  = 12;
   localparam int CFG_TX_TH_LSB  = 8;
   localparam int CFG_UFLOW_BIT  = 6;
   localparam int CFG_INTERNAL_CODEC_SELECT_BIT   = 5;
   localparam int CFG_FMT_BIT    = 4;
   localparam int CFG_SRST_BIT   = 3;
   localparam int CFG_BIT_CLOCK_DIRECTION_BIT   = 2;
   localparam int CFG_FRAME_SYNC_DIRECTION_BIT  = 1;
   localparam int CFG_EN_BIT     = 0;

   localparam logic [31:0] CONFIG_RST      = 32'h0000_7800;
   localparam logic [31:0] FIFO_STATUS_RST = 32'h0000_0008;
   localparam logic [31:0] BCLK_DIV_RST    = 32'h0000_0003;

   // fifo status fields
   localparam int STAT_RX_LVL_LSB = 24;
   localparam int STAT_TX_LVL_LSB = 8;
   localparam int STAT_RX_FLAG    = 4;
   localparam int STAT_TX_FLAG    = 3;
   localparam int STAT_TX_UFLOW   = 2;
   localparam int STAT_RX_OFLOW   = 1;

   ////////////////////////////////////////////////////////////////////////////////
   // fifo and frame geometry
   localparam int SAMPLE_W   = 24;
   localparam int FIFO_DEPTH = 32;
   localparam int LEVEL_W    = 6;
   localparam int FRAME_BITS = 64;

   typedef struct packed {
      logic [3:0] rx_threshold;
      logic [3:0] tx_threshold;
      logic       underflow_policy;
      logic       internal_codec_select;
      logic       link_format_select;
      logic       bit_clock_direction;
      logic       frame_sync_direction;
      logic       controller_enable;
   } cfg_t;

   typedef struct packed {
      logic               valid;
      logic [SAMPLE_W-1:0] data;
   } sample_t;

endpackage

// ### sample_fifo.sv
module sample_fifo
   import audio_link_pkg::*;
(
   // clock and reset
   input  wire logic                core_clk,
   input  wire logic                srst,
   // fill side
   input  wire logic                push,
   input  wire logic [SAMPLE_W-1:0] push_data,
   output logic                     full,
   // drain side
   input  wire logic                pop,
   output logic [SAMPLE_W-1:0]      head,
   output logic                     empty,
   output logic [LEVEL_W-1:0]       level
);

   logic [SAMPLE_W-1:0]  mem [FIFO_DEPTH];
   logic [LEVEL_W-2:0]   wr_ptr_r;
   logic [LEVEL_W-2:0]   rd_ptr_r;
   logic [LEVEL_W-1:0]   level_r;
   logic                 do_push;
   logic                 do_pop;

   // refused pushes and pops are simply dropped
   assign do_push = push && (level_r != LEVEL_W'(FIFO_DEPTH));
   assign do_pop  = pop && (level_r != '0);
   assign full    = (level_r == LEVEL_W'(FIFO_DEPTH));
   assign empty   = (level_r == '0);
   assign level   = level_r;
   assign head    = mem[rd_ptr_r];

   // storage, not reset: level gates every pop, but head is not gated
   always_ff @(posedge core_clk) begin
      if (do_push) begin
         mem[wr_ptr_r] <= push_data;
      end
   end

   // pointers and level
   always_ff @(posedge core_clk) begin
      if (srst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         level_r  <= '0;
      end else begin
         if (do_push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (do_pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         level_r <= level_r + LEVEL_W'(do_push) - LEVEL_W'(do_pop);
      end
   end

endmodule

// ### audio_serial_controller.sv
module audio_serial_controller
   import audio_link_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // memory-mapped register port
   input  wire logic [31:0] reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [31:0] reg_wdata,
   output logic [31:0]      reg_rdata,
   output logic             reg_rvalid,
   // serial link pins
   input  wire logic        bit_clk_in,
   output logic             bit_clk_out,
   output logic             bit_clk_oe_n,
   input  wire logic        sync_in,
   output logic             sync_out,
   output logic             sync_oe_n,
   input  wire logic        sdata_in,
   output logic             sdata_out,
   // codec routing
   output logic             internal_codec_sel
);

   ////////////////////////////////////////////////////////////////////////////////
   // register decode

   cfg_t                cfg_r;
   logic [31:0]         bit_clock_divider_r;
   logic [31:0]         gp_r [GP_N];
   logic [31:0]         codec_stat_address_r;
   logic [31:0]         codec_stat_data_r;
   logic                tx_uflow_r;
   logic                rx_oflow_r;
   logic                cmd_pending_r;
   logic                cfg_wr;
   logic                soft_rst;
   logic                srst;
   logic                data_wr;
   logic                data_rd;
   logic [31:0]         rdata_nxt;

   assign cfg_wr   = reg_wr && (reg_addr == ADDR_CONFIG);
   assign soft_rst = cfg_wr && reg_wdata[CFG_SRST_BIT];
   assign srst     = !rst_n || soft_rst;
   assign data_wr  = reg_wr && (reg_addr == ADDR_FIFO_DATA);
   assign data_rd  = reg_rd && (reg_addr == ADDR_FIFO_DATA);

   // configuration: survives soft reset, reserved bits never stored
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cfg_r <= cfg_t'({CONFIG_RST[15:8], CONFIG_RST[6:4], CONFIG_RST[2:0]});
      end else if (cfg_wr) begin
         cfg_r <= cfg_t'({reg_wdata[15:8], reg_wdata[6:4], reg_wdata[2:0]});
      end
   end

   // divider register survives soft reset as well
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         bit_clock_divider_r <= BCLK_DIV_RST;
      end else if (reg_wr && (reg_addr == ADDR_BCLK_DIVIDER)) begin
         bit_clock_divider_r <= reg_wdata;
      end
   end

   // plain storage registers, one per entry
   for (genvar g = 0; g < GP_N; g++) begin : gen_gp
      always_ff @(posedge core_clk) begin
         if (srst) begin
            gp_r[g] <= '0;
         end else if (reg_wr && (reg_addr == GP_ADDR[g])) begin
            gp_r[g] <= reg_wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // fifos

   logic                tx_full;
   logic                tx_empty;
   logic [SAMPLE_W-1:0] tx_head;
   logic [LEVEL_W-1:0]  tx_level;
   logic                tx_pop;
   logic                rx_full;
   logic                rx_empty;
   logic [SAMPLE_W-1:0] rx_head;
   logic [LEVEL_W-1:0]  rx_level;
   sample_t             rx_word;
   logic                tx_service_flag;
   logic                rx_service_flag;

   sample_fifo u_tx_fifo (
      .core_clk  (core_clk),
      .srst      (srst),
      .push      (data_wr),
      .push_data (reg_wdata[SAMPLE_W-1:0]),
      .full      (tx_full),
      .pop       (tx_pop),
      .head      (tx_head),
      .empty     (tx_empty),
      .level     (tx_level)
   );

   sample_fifo u_rx_fifo (
      .core_clk  (core_clk),
      .srst      (srst),
      .push      (rx_word.valid),
      .push_data (rx_word.data),
      .full      (rx_full),
      .pop       (data_rd),
      .head      (rx_head),
      .empty     (rx_empty),
      .level     (rx_level)
   );

   // flags follow the live level, no latching
   assign tx_service_flag = tx_level <= {1'b0, cfg_r.tx_threshold, 1'b0};
   assign rx_service_flag = rx_level >= ({1'b0, cfg_r.rx_threshold, 1'b0} + 6'h02);

   ////////////////////////////////////////////////////////////////////////////////
   // bit clock source and edges

   logic        fmt_i2s;
   logic        bclk_gen;
   logic        sync_drv;
   logic        en;
   logic [31:0] div_cnt_r;
   logic        gen_bclk_r;
   logic        div_tc;
   logic        bclk_in_q_r;
   logic        bit_rise;
   logic        bit_fall;

   assign fmt_i2s  = cfg_r.link_format_select;
   assign bclk_gen = fmt_i2s && cfg_r.bit_clock_direction;
   assign sync_drv = !fmt_i2s || cfg_r.frame_sync_direction;
   assign en       = cfg_r.controller_enable;
   assign div_tc   = (div_cnt_r >= bit_clock_divider_r);

   // each half period of the generated clock lasts divider+1 core cycles
   always_ff @(posedge core_clk) begin
      if (srst || !en || !bclk_gen) begin
         div_cnt_r  <= '0;
         gen_bclk_r <= 1'b0;
      end else if (div_tc) begin
         div_cnt_r  <= '0;
         gen_bclk_r <= !gen_bclk_r;
      end else begin
         div_cnt_r  <= div_cnt_r + 32'h0000_0001;
      end
   end

   // received clock is sampled like any other synchronous input
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         bclk_in_q_r <= 1'b0;
      end else begin
         bclk_in_q_r <= bit_clk_in;
      end
   end

   always_comb begin
      if (bclk_gen) begin
         bit_rise = en && div_tc && !gen_bclk_r;
         bit_fall = en && div_tc && gen_bclk_r;
      end else begin
         bit_rise = en && bit_clk_in && !bclk_in_q_r;
         bit_fall = en && !bit_clk_in && bclk_in_q_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // frame counter and transmit serializer

   logic [5:0]          bit_cnt_r;
   logic [5:0]          cnt_nxt;
   logic                sync_prev_r;
   logic                tx_load;
   logic [SAMPLE_W-1:0] tx_shift_r;
   logic [SAMPLE_W-1:0] last_sample_r;
   logic [SAMPLE_W-1:0] tx_sample;
   logic                slot_cmd;

   // an incoming frame sync edge realigns the channel boundary
   always_comb begin
      if (!sync_drv && (sync_in != sync_prev_r)) begin
         cnt_nxt = {sync_in, 5'h00};
      end else begin
         cnt_nxt = bit_cnt_r + 6'h01;
      end
   end

   assign tx_load  = bit_fall && (cnt_nxt[4:0] == 5'h00);
   assign slot_cmd = cmd_pending_r && !fmt_i2s;
   assign tx_pop   = tx_load && !slot_cmd && !tx_empty;

   // command slots replace audio for one frame; empty fifo obeys policy
   always_comb begin
      if (slot_cmd) begin
         tx_sample = cnt_nxt[5] ? gp_r[GP_CMD_DATA][SAMPLE_W-1:0] : gp_r[GP_CMD_ADDR][SAMPLE_W-1:0];
      end else if (!tx_empty) begin
         tx_sample = tx_head;
      end else if (cfg_r.underflow_policy) begin
         tx_sample = last_sample_r;
      end else begin
         tx_sample = '0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst || !en) begin
         bit_cnt_r   <= '0;
         sync_prev_r <= 1'b0;
      end else if (bit_fall) begin
         bit_cnt_r   <= cnt_nxt;
         sync_prev_r <= sync_in;
      end
   end

   // shifter: msb first, zero pad after the sample width
   always_ff @(posedge core_clk) begin
      if (srst || !en) begin
         tx_shift_r <= '0;
      end else if (tx_load) begin
         tx_shift_r <= tx_sample;
      end else if (bit_fall) begin
         tx_shift_r <= {tx_shift_r[SAMPLE_W-2:0], 1'b0};
      end
   end

   // the last real sample is what a repeat policy plays again
   always_ff @(posedge core_clk) begin
      if (srst) begin
         last_sample_r <= '0;
      end else if (tx_pop) begin
         last_sample_r <= tx_head;
      end
   end

   // a command data write arms one command frame
   always_ff @(posedge core_clk) begin
      if (srst) begin
         cmd_pending_r <= 1'b0;
      end else if (reg_wr && (reg_addr == GP_ADDR[GP_CMD_DATA])) begin
         cmd_pending_r <= 1'b1;
      end else if (tx_load && cnt_nxt[5] && slot_cmd) begin
         cmd_pending_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // receive deserializer

   logic [SAMPLE_W-1:0] rx_shift_r;
   logic                rx_done;
   logic [SAMPLE_W-1:0] rx_full_word;

   assign rx_done      = bit_rise && (bit_cnt_r[4:0] == 5'(SAMPLE_W - 1));
   assign rx_full_word = {rx_shift_r[SAMPLE_W-2:0], sdata_in};
   assign rx_word      = '{valid: rx_done && fmt_i2s, data: rx_full_word};

   always_ff @(posedge core_clk) begin
      if (srst || !en) begin
         rx_shift_r <= '0;
      end else if (bit_rise) begin
         rx_shift_r <= rx_full_word;
      end
   end

   // on the AC-link, received slots carry codec register replies
   always_ff @(posedge core_clk) begin
      if (srst) begin
         codec_stat_address_r <= '0;
         codec_stat_data_r    <= '0;
      end else if (rx_done && !fmt_i2s) begin
         if (bit_cnt_r[5]) begin
            codec_stat_data_r    <= 32'(rx_full_word);
         end else begin
            codec_stat_address_r <= 32'(rx_full_word);
         end
      end
   end

   // sticky errors: hardware set wins over a software clear
   always_ff @(posedge core_clk) begin
      if (srst) begin
         tx_uflow_r <= FIFO_STATUS_RST[STAT_TX_UFLOW];
         rx_oflow_r <= FIFO_STATUS_RST[STAT_RX_OFLOW];
      end else begin
         if (tx_load && !slot_cmd && tx_empty) begin
            tx_uflow_r <= 1'b1;
         end else if (reg_wr && (reg_addr == ADDR_FIFO_STATUS) && !reg_wdata[STAT_TX_UFLOW]) begin
            tx_uflow_r <= 1'b0;
         end
         if (rx_word.valid && rx_full) begin
            rx_oflow_r <= 1'b1;
         end else if (reg_wr && (reg_addr == ADDR_FIFO_STATUS) && !reg_wdata[STAT_RX_OFLOW]) begin
            rx_oflow_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read mux and pins

   always_comb begin
      rdata_nxt = '0;
      case (reg_addr)
         ADDR_CONFIG: begin
            rdata_nxt[15:8] = {cfg_r.rx_threshold, cfg_r.tx_threshold};
            rdata_nxt[6:4]  = {cfg_r.underflow_policy, cfg_r.internal_codec_select, fmt_i2s};
            rdata_nxt[2:0]  = {cfg_r.bit_clock_direction, cfg_r.frame_sync_direction, en};
         end
         ADDR_FIFO_STATUS: begin
            rdata_nxt[STAT_RX_LVL_LSB +: LEVEL_W] = rx_level;
            rdata_nxt[STAT_TX_LVL_LSB +: LEVEL_W] = tx_level;
            rdata_nxt[STAT_RX_FLAG]               = rx_service_flag;
            rdata_nxt[STAT_TX_FLAG]               = tx_service_flag;
            rdata_nxt[STAT_TX_UFLOW]              = tx_uflow_r;
            rdata_nxt[STAT_RX_OFLOW]              = rx_oflow_r;
         end
         ADDR_STAT_ADDRESS: rdata_nxt = codec_stat_address_r;
         ADDR_STAT_DATA:    rdata_nxt = codec_stat_data_r;
         ADDR_BCLK_DIVIDER: rdata_nxt = bit_clock_divider_r;
         ADDR_FIFO_DATA:    rdata_nxt = 32'(rx_head);
         default: begin
            for (int i = 0; i < GP_N; i++) begin
               if (reg_addr == GP_ADDR[i]) begin
                  rdata_nxt = gp_r[i];
               end
            end
         end
      endcase
   end

   // read answer one cycle after the request
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         reg_rdata  <= '0;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rdata  <= reg_rd ? rdata_nxt : 32'h0000_0000;
         reg_rvalid <= reg_rd;
      end
   end

   // directions follow format and direction bits even when disabled; driven pins idle low
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         bit_clk_oe_n       <= 1'b1;
         sync_oe_n          <= 1'b1;
         bit_clk_out        <= 1'b0;
         sync_out           <= 1'b0;
         sdata_out          <= 1'b0;
         internal_codec_sel <= 1'b0;
      end else begin
         bit_clk_oe_n       <= !bclk_gen;
         sync_oe_n          <= !sync_drv;
         bit_clk_out        <= en && bclk_gen && gen_bclk_r;
         sync_out           <= en && sync_drv && bit_cnt_r[5];
         sdata_out          <= en && tx_shift_r[SAMPLE_W-1];
         internal_codec_sel <= cfg_r.internal_codec_select;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence s_cfg_read;
      reg_rd && (reg_addr == ADDR_CONFIG);
   endsequence

   sequence s_empty_zero_load;
      tx_load && tx_empty && !slot_cmd && !cfg_r.underflow_policy && en;
   endsequence

   a_cfg_reserved_zero: assert property (s_cfg_read |=> reg_rdata[31:16] == '0 && !reg_rdata[7] && !reg_rdata[3])
      else $error("config reserved or reset bit read nonzero");
   a_tx_flag_empty: assert property (reg_rd && (reg_addr == ADDR_FIFO_STATUS) && tx_empty |=> reg_rdata[STAT_TX_FLAG])
      else $error("tx service flag clear with empty fifo");
   a_rx_flag_low: assert property (reg_rd && (reg_addr == ADDR_FIFO_STATUS) && rx_level < 6'h02 |=> !reg_rdata[STAT_RX_FLAG])
      else $error("rx service flag set below two samples");
   a_soft_reset_keep: assert property (soft_rst |=> tx_empty && rx_empty && en == $past(reg_wdata[CFG_EN_BIT]))
      else $error("soft reset did not clear fifos or lost config");
   a_divider_reset: assert property (@(posedge core_clk) disable iff (1'b0) !rst_n |=> bit_clock_divider_r == BCLK_DIV_RST)
      else $error("divider reset value wrong");
   a_aclink_sync_drive: assert property (!fmt_i2s |=> !sync_oe_n && bit_clk_oe_n)
      else $error("ac-link pin directions wrong");
   a_disabled_low: assert property (!en [*2] |-> !bit_clk_out && !sync_out && !sdata_out)
      else $error("disabled controller drives a pin high");
   a_underflow_zero: assert property (s_empty_zero_load |=> ##1 !sdata_out)
      else $error("zero policy underflow sent a one");
   a_data_push: assert property (data_wr && !tx_full && !tx_pop |=> tx_level == $past(tx_level) + 6'h01)
      else $error("data port write did not push");
   a_codec_route: assert property (##1 internal_codec_sel == $past(cfg_r.internal_codec_select))
      else $error("codec select not following config");

endmodule

// ### codec_model.sv
module codec_model (
   // pins seen from the codec
   input  wire logic core_clk,
   input  wire logic bclk,
   input  wire logic run,
   output logic      bclk_drv,
   output logic      sync_drv,
   output logic      sdata_drv
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [8:0] div_r = 9'h000;
   // clock stands still unless a frame is asked for; a bit lasts eight core cycles,
   // and sync turns on a clock fall every 32 bits so each channel slot is full width
   always @(posedge core_clk) begin
      div_r <= run ? div_r + 9'h001 : 9'h000;
      bclk_drv <= run & div_r[2];
      sync_drv <= run & div_r[8];
   end
   // data flips on every fall so a stale level never passes for a bit
   initial sdata_drv = 1'b0;
   always @(negedge bclk) sdata_drv <= ~sdata_drv;
endmodule

// ### tb.sv
module tb;
   import audio_link_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [31:0] reg_addr = 32'h0, reg_wdata = 32'h0, reg_rdata;
   logic reg_rvalid, bit_clk_out, bit_clk_oe_n, sync_out, sync_oe_n, sdata_out, icsel, bdrv, sdrv, ddrv;
   int fails = 0, n_checks = 0;
   logic run = 1'b0;
   // pin level: whoever has the enable drives
   wire bclk_w = bit_clk_oe_n ? bdrv : bit_clk_out;
   wire sync_w = sync_oe_n ? sdrv : sync_out;
   always #20 core_clk = ~core_clk;
   audio_serial_controller dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .bit_clk_in(bclk_w), .bit_clk_out(bit_clk_out), .bit_clk_oe_n(bit_clk_oe_n), .sync_in(sync_w),
      .sync_out(sync_out), .sync_oe_n(sync_oe_n), .sdata_in(ddrv), .sdata_out(sdata_out),
      .internal_codec_sel(icsel));
   codec_model partner (.core_clk(core_clk), .bclk(bclk_w), .run(run), .bclk_drv(bdrv), .sync_drv(sdrv),
      .sdata_drv(ddrv));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // strobes rise just after an edge and drop after the taking edge
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge core_clk);
      #2;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge core_clk);
      #2;
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      @(posedge core_clk);
      #2;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge core_clk);
      #2;
      reg_rd = 1'b0;
      chk({31'h0, reg_rvalid}, 32'h1);
      chk(reg_rdata, exp);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rd(ADDR_CONFIG, CONFIG_RST);
      rd(ADDR_FIFO_STATUS, FIFO_STATUS_RST);
      rd(ADDR_BCLK_DIVIDER, BCLK_DIV_RST);
      rd(ADDR_STAT_DATA, 32'h0);
      rd(32'h1002_0038, 32'h0);
      chk({30'h0, bit_clk_oe_n, sync_oe_n}, 32'h2);
      $display("test reset done");
   endtask
   task automatic t_roles;
      logic [31:0] cfg [5] = '{32'hFFFF_FFFE, 32'h14, 32'h12, 32'h10, 32'h06};
      logic [1:0] oe [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2};
      wr(ADDR_CONFIG, cfg[0]);
      rd(ADDR_CONFIG, 32'h0000_FF76);
      for (int i = 0; i < 5; i++) begin
         wr(ADDR_CONFIG, cfg[i]);
         repeat (2) @(posedge core_clk);
         #2;
         chk({26'h0, icsel, bit_clk_oe_n, sync_oe_n, bit_clk_out, sync_out, sdata_out},
             {26'h0, cfg[i][5], oe[i], 3'h0});
      end
      $display("test roles done");
   endtask
   task automatic t_fifo;
      wr(ADDR_CONFIG, 32'h0000_0200);
      wr(ADDR_CMD_ADDRESS, 32'h0000_1234);
      rd(ADDR_CMD_ADDRESS, 32'h0000_1234);
      repeat (4) wr(ADDR_FIFO_DATA, 32'h1);
      rd(ADDR_FIFO_STATUS, 32'h0000_0408);
      wr(ADDR_FIFO_DATA, 32'h2);
      rd(ADDR_FIFO_STATUS, 32'h0000_0500);
      wr(ADDR_CONFIG, 32'h0000_0208);
      rd(ADDR_CONFIG, 32'h0000_0200);
      rd(ADDR_FIFO_STATUS, 32'h8);
      rd(ADDR_CMD_ADDRESS, 32'h0);
      $display("test fifo done");
   endtask
   // right slot is checked: enable starts the count at zero, so no left slot loads before it
   task automatic t_serial(input logic [31:0] cfg, input logic [23:0] exp);
      logic [23:0] got;
      logic prev;
      prev = 1'b1;
      wr(ADDR_CONFIG, cfg);
      // codec clock starts only after enable, so both frame counters agree
      run = !cfg[CFG_BIT_CLOCK_DIRECTION_BIT];
      // pins, not outputs: in slave roles the codec model owns clock and sync
      repeat (1200) begin
         @(posedge core_clk);
         #2;
         if (sync_w && !prev) break;
         prev = sync_w;
      end
      for (int i = 23; i >= 0; i--) begin
         @(posedge bclk_w);
         #1;
         got[i] = sdata_out;
      end
      chk({8'h0, got}, {8'h0, exp});
      // stop the link clock before the controller is disabled
      run = 1'b0;
      wr(ADDR_CONFIG, 32'h10);
      repeat (2) @(posedge core_clk);
      #2;
      chk({29'h0, bit_clk_out, sync_out, sdata_out}, 32'h0);
      $display("test serial done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge core_clk);
      #2;
      rst_n = 1'b1;
      t_reset;
      t_roles;
      t_fifo;
      wr(ADDR_FIFO_DATA, 32'h00A5_C396);
      t_serial(32'h57, 24'hA5_C396);
      t_serial(32'h17, 24'h0);
      t_serial(32'h57, 24'hA5_C396);
      wr(ADDR_FIFO_DATA, 32'h005A_3C69);
      t_serial(32'h11, 24'h5A_3C69);
      conclude;
   end
   // about seven times the expected run
   initial begin
      #540000;
      fails++;
      conclude;
   end
endmodule
